// file: hw/failsafe_defines.svh
// Offsets, reset values, field positions and timing constants of the failsafe block.
// Assumes AXI4-Lite byte addressing with one aligned 32-bit word per register.
`ifndef FAILSAFE_DEFINES_SVH
`define FAILSAFE_DEFINES_SVH

`define ADDR_HOLD 3'h0
`define ADDR_SEL_LO 3'h1
`define ADDR_SEL_HI 3'h2
`define ADDR_SPEED 3'h3
`define ADDR_SUPPORT 3'h4
`define ADDR_PTO 3'h5
`define ADDR_FAIL 3'h6
`define ADDR_STATUS 3'h7

`define HOLD_RST 24'hE3E000
`define SEL_LO_RST 32'h03020100
`define SEL_HI_RST 32'h07060504
`define PPR_RST 8'h06
`define THR_RST 14'h003C
`define SUPPORT_RST 4'hF
`define PTO_MODE_RST 9'h0C9
`define PTO_EVAL_RST 3'h0

`define SEL_STRIDE 8
`define SPD_THR_LSB 16
`define PTO_MODE_STRIDE 4
`define PTO_EVAL_LSB 16
`define PTO_FBO_BIT 20
`define PTO_REQ_BIT 21
`define ST_SPEED_BIT 8
`define ST_REQ_LSB 9
`define ST_ISC_LSB 15

`define NUM_SRC 5'd24
`define CLK_HZ 33'd125000000
`define HALF_PER_MIN 33'd30
`define SPD_LIM (`HALF_PER_MIN * `CLK_HZ)

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: hw/failsafe_pkg.sv
// Types shared by the failsafe block and its surroundings.
// Assumes failsafe_defines.svh supplies the numeric constants.
package failsafe_pkg;
	typedef logic [23:0] src_vec_t;
	typedef struct packed {
		src_vec_t val;
		src_vec_t fresh;
		src_vec_t timeout;
		src_vec_t implaus;
	} src_s;
	typedef struct packed {
		logic [5:0] digital;
		logic [5:0] can;
	} req_s;
	typedef struct packed {
		logic [2:0] mode;
		logic eval;
	} pto_s;
endpackage : failsafe_pkg

// file: hw/output_failsafe.sv
// Output failsafe, engine-speed pulse, request selection and take-off mode request.
// Assumes one 125 MHz clock, synchronous inputs and an AXI4-Lite master for configuration.
// What this block does
// - Non-holding output goes passive on source failure
// - Holding output stays active while source failed
// - After ignition reset, failed holding output stays passive
// - Take-off feedbacks and warnings default to holding
// - Speed square wave, 6 pulses, above 60 rpm
// - Speed-control requests: digital if supported, else CAN
// - Clutch/neutral request: digital if supported, else CAN
// - Lockup/up-shift requests chosen by support setting
// - Each take-off assignable any of seven modes
// - Take-offs 1,2 on feedback; third also on request
// - Assigned mode ignored unless evaluation enabled
// - Simultaneous requests OR their mode lines
// - Mode encoded binary on lines A,B,C
// - Device request overrides wired mode pins
// - Defaults: modes 1,1,3, evaluation disabled
// - Feedback-only evaluation exists for third take-off only
`include "failsafe_defines.svh"

module output_failsafe
	import failsafe_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// AXI4-Lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Mapped source signals and ignition-terminal reset pulse
	input wire src_s src,
	input wire logic ign_reset,
	// Switch output drivers: high side 1..5, low side 1..3
	output logic [7:0] drivers,
	// Engine speed
	input wire logic [13:0] engine_rpm,
	output logic speed_pulse,
	// Requests: set+, set-, mem off, clutch/neutral, lockup open, up-shift interlock
	input wire req_s req_in,
	output logic [5:0] req_out,
	// Take-off feedback, wired mode pins and mode request lines C,B,A
	input wire logic [2:0] pto_fb,
	input wire logic [2:0] wired_mode,
	output logic [2:0] isc_mode
);

	localparam logic [63:0] SEL_RST = {`SEL_HI_RST, `SEL_LO_RST};
	// Literal defaults cannot be part-selected directly, so they live in named constants
	localparam logic [8:0] PTO_MODE_DEF = `PTO_MODE_RST;
	localparam logic [2:0] PTO_EVAL_DEF = `PTO_EVAL_RST;

	function automatic logic src_bit(input src_vec_t v, input logic [4:0] idx);
		// An index past the last source means no source: reads as zero
		src_bit = (idx < `NUM_SRC) ? v[idx] : 1'b0;
	endfunction : src_bit

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		wmerge = r;
	endfunction : wmerge

	src_vec_t hold_r;
	src_vec_t fail_r;
	logic [4:0] sel_r [8];
	logic [7:0] ppr_r;
	logic [13:0] thr_r;
	logic [3:0] sup_r;
	pto_s pto_r [3];
	logic fbo3_r;
	logic req3_r;
	logic [7:0] drv_r;
	logic speed_r;
	logic [32:0] acc_r;
	logic [5:0] req_r;
	logic [2:0] isc_r;
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic [31:0] regs_v [8];
	logic wr_do;
	logic [2:0] widx;
	logic [31:0] wv;

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign drivers = drv_r;
	assign speed_pulse = speed_r;
	assign req_out = req_r;
	assign isc_mode = isc_r;

	// Register read view
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			regs_v[i] = 32'h0;
		end
		regs_v[`ADDR_HOLD][23:0] = hold_r;
		for (int k = 0; k < 8; k++) begin
			regs_v[`ADDR_SEL_LO + 3'(k / 4)][`SEL_STRIDE * (k % 4) +: 5] = sel_r[k];
		end
		regs_v[`ADDR_SPEED][7:0] = ppr_r;
		regs_v[`ADDR_SPEED][`SPD_THR_LSB +: 14] = thr_r;
		regs_v[`ADDR_SUPPORT][3:0] = sup_r;
		for (int p = 0; p < 3; p++) begin
			regs_v[`ADDR_PTO][`PTO_MODE_STRIDE * p +: 3] = pto_r[p].mode;
			regs_v[`ADDR_PTO][`PTO_EVAL_LSB + p] = pto_r[p].eval;
		end
		regs_v[`ADDR_PTO][`PTO_FBO_BIT] = fbo3_r;
		regs_v[`ADDR_PTO][`PTO_REQ_BIT] = req3_r;
		regs_v[`ADDR_FAIL][23:0] = fail_r;
		regs_v[`ADDR_STATUS][7:0] = drv_r;
		regs_v[`ADDR_STATUS][`ST_SPEED_BIT] = speed_r;
		regs_v[`ADDR_STATUS][`ST_REQ_LSB +: 6] = req_r;
		regs_v[`ADDR_STATUS][`ST_ISC_LSB +: 3] = isc_r;
	end

	// Write fires once both address and data are held and no response is pending
	assign wr_do = !awready_r && !wready_r && !bvalid_r;
	assign widx = aw_addr_r[4:2];
	assign wv = wmerge(regs_v[widx], w_data_r, w_strb_r);

	// AXI write channels
	always_ff @(posedge clk) begin
		if (!nrst) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
		end else begin
			if (awvalid && awready_r) begin
				awready_r <= 1'b0;
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready_r) begin
				wready_r <= 1'b0;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end
			if (wr_do) begin
				bvalid_r <= 1'b1;
				bresp_r <= (aw_addr_r[7:5] == 3'h0) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// AXI read channels
	always_ff @(posedge clk) begin
		if (!nrst) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= `RESP_OKAY;
		end else if (arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= (araddr[7:5] == 3'h0) ? regs_v[araddr[4:2]] : 32'h0;
			rresp_r <= (araddr[7:5] == 3'h0) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// Configuration registers; status words ignore writes
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hold_r <= `HOLD_RST;
			for (int k = 0; k < 8; k++) begin
				sel_r[k] <= SEL_RST[`SEL_STRIDE * k +: 5];
			end
			ppr_r <= `PPR_RST;
			thr_r <= `THR_RST;
			sup_r <= `SUPPORT_RST;
			for (int p = 0; p < 3; p++) begin
				pto_r[p].mode <= PTO_MODE_DEF[3 * p +: 3];
				pto_r[p].eval <= PTO_EVAL_DEF[p];
			end
			fbo3_r <= 1'b0;
			req3_r <= 1'b0;
		end else if (wr_do && aw_addr_r[7:5] == 3'h0) begin
			unique case (widx)
				`ADDR_HOLD: hold_r <= wv[23:0];
				`ADDR_SEL_LO, `ADDR_SEL_HI: begin
					for (int k = 0; k < 4; k++) begin
						sel_r[4 * (widx - `ADDR_SEL_LO) + 3'(k)] <= wv[`SEL_STRIDE * k +: 5];
					end
				end
				`ADDR_SPEED: begin
					ppr_r <= wv[7:0];
					thr_r <= wv[`SPD_THR_LSB +: 14];
				end
				`ADDR_SUPPORT: sup_r <= wv[3:0];
				`ADDR_PTO: begin
					for (int p = 0; p < 3; p++) begin
						pto_r[p].mode <= wv[`PTO_MODE_STRIDE * p +: 3];
						pto_r[p].eval <= wv[`PTO_EVAL_LSB + p];
					end
					// Only the third take-off has a feedback-only bit; the first two have none to set
					fbo3_r <= wv[`PTO_FBO_BIT];
					req3_r <= wv[`PTO_REQ_BIT];
				end
				`ADDR_FAIL, `ADDR_STATUS: begin
				end
			endcase
		end
	end

	// Failure flags: a new fault in the same cycle as a valid value keeps the flag set
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fail_r <= 24'h0;
		end else begin
			fail_r <= src.timeout | src.implaus | (fail_r & ~src.fresh);
		end
	end

	// Switch output drivers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			drv_r <= 8'h00;
		end else begin
			for (int k = 0; k < 8; k++) begin
				if (ign_reset) begin
					drv_r[k] <= 1'b0;
				end else if (!src_bit(fail_r, sel_r[k])) begin
					drv_r[k] <= src_bit(src.val, sel_r[k]);
				end else if (!src_bit(hold_r, sel_r[k])) begin
					drv_r[k] <= 1'b0;
				end else begin
					// A passive driver stays passive, so a failure across ignition reset holds it off
					drv_r[k] <= drv_r[k];
				end
			end
		end
	end

	// Engine speed: toggle rate is rpm*ppr/30 per second, by phase accumulation
	logic [32:0] acc_sum;
	// Product widened first: inside a concatenation it would otherwise wrap at 14 bits
	assign acc_sum = acc_r + {11'h0, 22'(engine_rpm) * 22'(ppr_r)};

	always_ff @(posedge clk) begin
		if (!nrst || engine_rpm <= thr_r) begin
			acc_r <= 33'h0;
			speed_r <= 1'b0;
		end else if (acc_sum >= `SPD_LIM) begin
			acc_r <= acc_sum - `SPD_LIM;
			speed_r <= !speed_r;
		end else begin
			acc_r <= acc_sum;
		end
	end

	// Request source selection
	logic [5:0] sup6;
	assign sup6 = {sup_r[3], sup_r[2], sup_r[1], {3{sup_r[0]}}};

	always_ff @(posedge clk) begin
		if (!nrst) begin
			req_r <= 6'h00;
		end else begin
			req_r <= (req_in.digital & sup6) | (req_in.can & ~sup6);
		end
	end

	// Take-off mode request
	logic [2:0] pto_req;
	logic [2:0] pto_act;
	logic [2:0] mode_or;
	assign pto_req = {pto_fb[2] | (req3_r & !fbo3_r), pto_fb[1:0]};
	always_comb begin
		mode_or = 3'h0;
		for (int p = 0; p < 3; p++) begin
			pto_act[p] = pto_req[p] && pto_r[p].eval;
			mode_or = mode_or | (pto_act[p] ? pto_r[p].mode : 3'h0);
		end
	end

	// The mode code sits on the lines as bit0=A, bit1=B, bit2=C
	always_ff @(posedge clk) begin
		if (!nrst) begin
			isc_r <= 3'h0;
		end else begin
			isc_r <= (|pto_act) ? mode_or : wired_mode;
		end
	end

	for (genvar k = 0; k < 8; k++) begin : g_chk
		sequence ign_then_held_fail;
			ign_reset ##1 (src_bit(fail_r, sel_r[k]) && src_bit(hold_r, sel_r[k]) && !ign_reset);
		endsequence
		nohold_fail_a: assert property (@(posedge clk) disable iff (!nrst)
			src_bit(fail_r, sel_r[k]) && !src_bit(hold_r, sel_r[k]) && !ign_reset |=> !drv_r[k])
			else $error("non-holding driver not passive on failure");
		hold_keep_a: assert property (@(posedge clk) disable iff (!nrst)
			src_bit(fail_r, sel_r[k]) && src_bit(hold_r, sel_r[k]) && !ign_reset |=> drv_r[k] == $past(drv_r[k]))
			else $error("holding driver changed during failure");
		ign_passive_a: assert property (@(posedge clk) disable iff (!nrst)
			ign_then_held_fail |=> !drv_r[k])
			else $error("held driver active after ignition reset");
	end

	hold_default_a: assert property (@(posedge clk)
		!nrst |=> hold_r == `HOLD_RST && pto_r[2].mode == 3'h3 && !pto_r[0].eval)
		else $error("reset defaults wrong");
	speed_gate_a: assert property (@(posedge clk) disable iff (!nrst)
		engine_rpm <= thr_r |=> !speed_r && acc_r == 33'h0)
		else $error("speed output active below threshold");
	speed_edge_a: assert property (@(posedge clk) disable iff (!nrst)
		$changed(speed_r) |-> $past(engine_rpm > thr_r && acc_sum >= `SPD_LIM) || $fell(speed_r))
		else $error("speed output toggled without wrap");
	req_setpm_a: assert property (@(posedge clk) disable iff (!nrst)
		##1 req_r[2:0] == $past(sup_r[0] ? req_in.digital[2:0] : req_in.can[2:0]))
		else $error("speed-control request from wrong source");
	req_clutch_a: assert property (@(posedge clk) disable iff (!nrst)
		##1 req_r[3] == $past(sup_r[1] ? req_in.digital[3] : req_in.can[3]))
		else $error("clutch request from wrong source");
	req_lockup_a: assert property (@(posedge clk) disable iff (!nrst)
		##1 req_r[5:4] == $past({sup_r[3] ? req_in.digital[5] : req_in.can[5], sup_r[2] ? req_in.digital[4] : req_in.can[4]}))
		else $error("lockup or up-shift request from wrong source");
	pto_first_a: assert property (@(posedge clk) disable iff (!nrst)
		pto_fb[0] && pto_r[0].eval && !pto_fb[1] && !pto_fb[2] && !req3_r |=> isc_r == $past(pto_r[0].mode))
		else $error("first take-off mode not requested");
	isc_wired_a: assert property (@(posedge clk) disable iff (!nrst)
		!(|pto_act) |=> isc_r == $past(wired_mode))
		else $error("wired mode not passed when idle");
	isc_or_a: assert property (@(posedge clk) disable iff (!nrst)
		&pto_act |=> isc_r == $past(pto_r[0].mode | pto_r[1].mode | pto_r[2].mode))
		else $error("combined mode lines not ORed");
	fail_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		src.fresh[0] && !src.timeout[0] && !src.implaus[0] |=> !fail_r[0])
		else $error("failure flag not cleared on valid value");

endmodule : output_failsafe

// file: tb/speed_ctrl_model.sv
// Far-side speed-control model: runs the requested mode only when its own precondition holds.
// Assumes the device's mode lines are registered on the same clock.
module speed_ctrl_model (
	// Clock
	input wire logic clk,
	// Mode lines and precondition
	input wire logic [2:0] isc_mode,
	input wire logic gear_neutral,
	// Mode actually running
	output logic [2:0] active_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	// The lines are taken as they arrive, so wired pins lose whenever the device drives a request
	always_ff @(posedge clk) begin
		active_mode <= gear_neutral ? isc_mode : 3'h0;
	end
endmodule : speed_ctrl_model

// file: tb/test_output_failsafe.sv
// Self-checking bench for the output failsafe block: registers, failsafe, requests, mode lines, speed pulse.
// Assumes the design and the far-side model are compiled first; one 125 MHz clock.
module test_output_failsafe
	import failsafe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, ign_reset, gear_neutral;
	logic awready, wready, bvalid, arready, rvalid, speed_pulse;
	logic [7:0] awaddr, araddr, drivers;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [13:0] engine_rpm;
	logic [5:0] req_out;
	logic [2:0] pto_fb, wired_mode, isc_mode, active_mode;
	src_s src;
	req_s req_in;
	int fails, n_compared;

	output_failsafe u_dut (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .src,
		.ign_reset, .drivers, .engine_rpm, .speed_pulse, .req_in, .req_out, .pto_fb, .wired_mode, .isc_mode);
	speed_ctrl_model u_far (.clk, .isc_mode, .gear_neutral, .active_mode);

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
			if (bvalid === 1'h1) break;
		end
		resp = bresp;
		bready <= 1'h0;
		if (n == 50) fails++;
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arready === 1'h1) arvalid <= 1'h0;
			if (rvalid === 1'h1) break;
		end
		rd = rdata;
		resp = rresp;
		rready <= 1'h0;
		if (n == 50) fails++;
	endtask : rdr

	// Leaves three edges for the failure flag and the driver stage to settle
	task automatic pulse(input int k);
		@(posedge clk);
		if (k == 0) src.timeout[2] <= 1'h1;
		else if (k == 1) src.fresh[2] <= 1'h1;
		else if (k == 2) src.implaus[2] <= 1'h1;
		else ign_reset <= 1'h1;
		@(posedge clk);
		src.timeout[2] <= 1'h0;
		src.fresh[2] <= 1'h0;
		src.implaus[2] <= 1'h0;
		ign_reset <= 1'h0;
		repeat (3) @(posedge clk);
	endtask : pulse

	task automatic settle(input logic [2:0] fb);
		@(posedge clk);
		pto_fb <= fb;
		repeat (3) @(posedge clk);
	endtask : settle

	task automatic span(input logic v, output int c);
		for (c = 0; c < 5000 && speed_pulse === v; c++) @(posedge clk);
	endtask : span

	task automatic t_defaults();
		rdr(8'h00);
		chk(32'h00E3E000, rd);
		rdr(8'h0C);
		chk(32'h003C0006, rd);
		rdr(8'h10);
		chk(32'h0000000F, rd);
		rdr(8'h14);
		chk(32'h00000311, rd);
		rdr(8'h20);
		chk(32'h2, 32'(resp));
		wr(8'h20, 32'h0);
		chk(32'h2, 32'(resp));
		$display("defaults done");
	endtask : t_defaults

	task automatic t_failsafe();
		@(posedge clk);
		src.val <= 24'hFFFFFF;
		repeat (3) @(posedge clk);
		chk(32'hFF, 32'(drivers));
		pulse(2);
		chk(32'hFB, 32'(drivers));
		pulse(1);
		chk(32'hFF, 32'(drivers));
		pulse(0);
		chk(32'hFB, 32'(drivers));
		pulse(1);
		wr(8'h00, 32'h00E3E004);
		chk(32'h0, 32'(resp));
		pulse(0);
		chk(32'hFF, 32'(drivers));
		pulse(3);
		chk(32'hFB, 32'(drivers));
		pulse(1);
		chk(32'hFF, 32'(drivers));
		$display("failsafe done");
	endtask : t_failsafe

	task automatic t_requests();
		@(posedge clk);
		req_in <= {6'h15, 6'h2A};
		repeat (3) @(posedge clk);
		chk(32'h15, 32'(req_out));
		wr(8'h10, 32'h0);
		repeat (3) @(posedge clk);
		chk(32'h2A, 32'(req_out));
		wr(8'h10, 32'h5);
		repeat (3) @(posedge clk);
		chk(32'h3D, 32'(req_out));
		$display("requests done");
	endtask : t_requests

	task automatic t_modes();
		@(posedge clk);
		wired_mode <= 3'h2;
		gear_neutral <= 1'h1;
		settle(3'h7);
		chk(32'h2, 32'(isc_mode));
		for (int m = 1; m < 8; m++) begin
			wr(8'h14, 32'h10000 | 32'(m));
			repeat (3) @(posedge clk);
			chk(32'(m), 32'(isc_mode));
		end
		settle(3'h6);
		chk(32'h2, 32'(isc_mode));
		wr(8'h14, 32'h00070421);
		repeat (3) @(posedge clk);
		chk(32'h6, 32'(isc_mode));
		settle(3'h3);
		chk(32'h3, 32'(isc_mode));
		settle(3'h0);
		wr(8'h14, 32'h00240421);
		repeat (3) @(posedge clk);
		chk(32'h4, 32'(isc_mode));
		chk(32'h4, 32'(active_mode));
		@(posedge clk);
		gear_neutral <= 1'h0;
		repeat (3) @(posedge clk);
		chk(32'h0, 32'(active_mode));
		wr(8'h14, 32'h00340421);
		repeat (3) @(posedge clk);
		chk(32'h2, 32'(isc_mode));
		$display("modes done");
	endtask : t_modes

	task automatic t_speed();
		int c, hi, lo;
		wr(8'h0C, 32'h003C00C8);
		@(posedge clk);
		engine_rpm <= 14'h30D4;
		span(1'h0, c);
		span(1'h1, hi);
		span(1'h0, lo);
		chk(32'(hi), 32'(lo));
		chk(32'h1, 32'(hi >= 1499 && hi <= 1501));
		@(posedge clk);
		engine_rpm <= 14'h003C;
		repeat (4) @(posedge clk);
		span(1'h0, c);
		chk(32'd5000, 32'(c));
		$display("speed done");
	endtask : t_speed

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		print_verdict();
	end

	initial begin
		{nrst, awvalid, wvalid, bready, arvalid, rready, ign_reset, gear_neutral} = 8'h00;
		{awaddr, araddr, wdata, wstrb, engine_rpm} = 66'h0;
		wstrb = 4'hF;
		src = '0;
		req_in = '0;
		{pto_fb, wired_mode} = 6'h00;
		repeat (16) @(posedge clk);
		nrst <= 1'h1;
		t_defaults();
		t_failsafe();
		t_requests();
		t_modes();
		t_speed();
		print_verdict();
	end
endmodule : test_output_failsafe
